// >>> verilog/sssp_strap_top.sv
// strap sampling at reset release and status pin reuse
// Contract
// - latch ganged strap at release: low per-port, high ganged switching
// - in SMBus mode, ganged strap level becomes slave address bit 2
// - with status enabled, drive ganged pin high when upstream high-speed
// - latch auto-charge strap; low enables automatic mode while unconnected
// - auto-charge strap low blocks charging downstream behaviour on port 1
// - latched auto-charge level is copied into the auto-charge disable bit
// - with status enabled, drive auto-charge pin high while suspended
// - serial mode strap low selects SMBus, high selects I2C
// - power strap low enables power switching
`timescale 1ns/1ps
`default_nettype none
module sssp_strap_top (
  input  wire logic  clock_i,
  input  wire logic  reset_n_i,
  input  wire logic  gang_pin_i,
  output var  logic  gang_pin_o,
  output var  logic  gang_pin_oe_o,
  input  wire logic  charge_auto_strap_i,
  output var  logic  charge_auto_strap_o,
  output var  logic  charge_auto_strap_oe_o,
  input  wire logic  serial_mode_strap_i,
  input  wire logic  power_switch_strap_i,
  input  wire logic  status_pin_enable_i,
  input  wire logic  hs_connected_i,
  input  wire logic  hs_suspended_i,
  input  wire logic  hub_connected_i,
  input  wire logic  [sssp_pkg::NUM_PORTS-1:0] charge_port_en_i,
  output var  logic  straps_valid_o,
  output var  logic  ganged_power_o,
  output var  logic  power_switch_en_o,
  output var  logic  smbus_mode_o,
  output var  logic  slave_addr_bit_two_o,
  output var  logic  auto_charge_disable_bit_o,
  output var  logic  auto_charge_active_o,
  output var  logic  [sssp_pkg::NUM_PORTS-1:0] cdp_allowed_o
);
  import sssp_pkg::*;

  sssp_strap_if lvl ();
  sssp_phase_t  phase_q;
  logic [1:0]   settle_q;
  logic gang_q, auto_q, serial_q, power_q;

  // run phase decode, shared by valid flag, auto mode and pin drive
  function automatic logic in_run(input sssp_phase_t ph);
    return (ph == SSSP_RUN);
  endfunction

  sssp_pin_sync u_sync (
    .clock_i      (clock_i),
    .reset_n_i    (reset_n_i),
    .gang_pin_i   (gang_pin_i),
    .auto_pin_i   (charge_auto_strap_i),
    .serial_pin_i (serial_mode_strap_i),
    .power_pin_i  (power_switch_strap_i),
    .lvl          (lvl)
  );

  // wait for synchronisers to fill, sample once, then run
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_q  <= SSSP_SETTLE;
      settle_q <= 2'h0;
    end else begin
      unique case (phase_q)
        SSSP_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == SETTLE_CYCLES) begin
            phase_q <= SSSP_SAMPLE;
          end
        end
        SSSP_SAMPLE: phase_q <= SSSP_RUN;
        SSSP_RUN:    phase_q <= SSSP_RUN;
        default:     phase_q <= SSSP_SETTLE;
      endcase
    end
  end

  // strap capture, only in the sample phase, held until reset
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gang_q   <= GANG_RESET_VAL;
      auto_q   <= AUTO_RESET_VAL;
      serial_q <= SERIAL_RESET_VAL;
      power_q  <= POWER_RESET_VAL;
    end else if (phase_q == SSSP_SAMPLE) begin
      gang_q   <= lvl.gang_lvl;
      auto_q   <= lvl.auto_lvl;
      serial_q <= lvl.serial_lvl;
      power_q  <= lvl.power_lvl;
    end
  end

  // decoded configuration outputs
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      straps_valid_o            <= 1'b0;
      ganged_power_o            <= 1'b0;
      power_switch_en_o         <= 1'b0;
      smbus_mode_o              <= 1'b0;
      slave_addr_bit_two_o      <= 1'b0;
      auto_charge_disable_bit_o <= AUTO_RESET_VAL;
      auto_charge_active_o      <= 1'b0;
      cdp_allowed_o             <= '0;
    end else begin
      straps_valid_o    <= in_run(phase_q);
      power_switch_en_o <= (power_q == POWER_STRAP_ENABLED);
      // ganged only meaningful while switching is enabled
      ganged_power_o    <= (power_q == POWER_STRAP_ENABLED) &&
                           (gang_q != GANG_SEL_INDIVIDUAL);
      smbus_mode_o      <= (serial_q == SERIAL_STRAP_SMBUS);
      slave_addr_bit_two_o <= (serial_q == SERIAL_STRAP_SMBUS)
                              && gang_q;
      auto_charge_disable_bit_o <= auto_q;
      auto_charge_active_o <= in_run(phase_q) &&
                              (auto_q == AUTO_STRAP_ENABLED) &&
                              !hub_connected_i;
      for (int p = 0; p < NUM_PORTS; p++) begin
        cdp_allowed_o[p] <= charge_port_en_i[p] && hub_connected_i &&
          !((p == CDP_BLOCKED_PORT - 1) &&
            (auto_q == AUTO_STRAP_ENABLED));
      end
    end
  end

  // status reuse of the strap pins after sampling
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gang_pin_o             <= 1'b0;
      gang_pin_oe_o          <= 1'b0;
      charge_auto_strap_o    <= 1'b0;
      charge_auto_strap_oe_o <= 1'b0;
    end else begin
      gang_pin_oe_o <= in_run(phase_q) &&
                       status_pin_enable_i;
      charge_auto_strap_oe_o <= in_run(phase_q) &&
                                status_pin_enable_i;
      // value bits track status while undriven; only oe reaches the pin
      gang_pin_o          <= hs_connected_i;
      charge_auto_strap_o <= hs_suspended_i;
    end
  end

  // checks: status pins stay released until sampled and enabled
  chk_status_drive_off: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) !status_pin_enable_i |=> !gang_pin_oe_o)
    else $error("ganged pin driven while status disabled");
  chk_auto_drive_off: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    !status_pin_enable_i |=> !charge_auto_strap_oe_o)
    else $error("auto-charge pin driven while status disabled");
  chk_early_drive_off: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (phase_q != SSSP_RUN) |=> !gang_pin_oe_o && !charge_auto_strap_oe_o)
    else $error("status pin driven before straps latched");
  chk_hs_link_up_out_level: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (phase_q == SSSP_RUN && status_pin_enable_i && hs_connected_i)
    |=> (gang_pin_oe_o && gang_pin_o))
    else $error("high-speed status not shown");
  chk_hs_link_up_out_low: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (phase_q == SSSP_RUN && status_pin_enable_i && !hs_connected_i)
    |=> (gang_pin_oe_o && !gang_pin_o))
    else $error("high-speed status shown while not connected");
  chk_suspend_level: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (phase_q == SSSP_RUN && status_pin_enable_i && hs_suspended_i)
    |=> (charge_auto_strap_oe_o && charge_auto_strap_o))
    else $error("suspend status not shown");
  chk_suspend_low: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (phase_q == SSSP_RUN && status_pin_enable_i && !hs_suspended_i)
    |=> (charge_auto_strap_oe_o && !charge_auto_strap_o))
    else $error("suspend status shown while awake");
  // latched straps never move in the run phase
  chk_strap_hold: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (phase_q == SSSP_RUN) |=> $stable(gang_q) && $stable(auto_q))
    else $error("latched strap changed");
  chk_mode_hold: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (phase_q == SSSP_RUN) |=> $stable(serial_q) && $stable(power_q))
    else $error("latched mode strap changed");
  // decoded outputs follow the latched levels one edge later
  chk_addr_bit_two: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (phase_q == SSSP_RUN) |=> slave_addr_bit_two_o ==
      $past(!serial_q && gang_q))
    else $error("slave address bit wrong");
  chk_disable_copy: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) 1'b1 |=> auto_charge_disable_bit_o ==
      $past(auto_q))
    else $error("disable bit not copied");
  chk_port_one_cdp: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) !auto_q |=> !cdp_allowed_o[0])
    else $error("port 1 cdp in auto mode");
  chk_cdp_other_port: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) (phase_q == SSSP_RUN) |=> cdp_allowed_o[1] ==
      $past(charge_port_en_i[1] && hub_connected_i))
    else $error("cdp wrongly blocked on port 2");
  chk_gang_mode: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) ganged_power_o |-> power_switch_en_o)
    else $error("ganged without switching");
  chk_gang_decode: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) 1'b1 |=> ganged_power_o ==
      $past(!power_q && gang_q))
    else $error("ganged power decode wrong");
  chk_smbus_sel: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) 1'b1 |=> smbus_mode_o == $past(!serial_q))
    else $error("serial mode decode wrong");
  chk_power_sel: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) 1'b1 |=> power_switch_en_o == $past(!power_q))
    else $error("power switch decode wrong");
  chk_auto_active: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) 1'b1 |=> auto_charge_active_o ==
      $past(phase_q == SSSP_RUN && !auto_q && !hub_connected_i))
    else $error("automatic charge mode decode wrong");
endmodule
`default_nettype wire

// >>> verilog/sssp_pkg.sv
// constants and types for the strap sample and status pin block
package sssp_pkg;
  // strap levels and their meanings
  localparam logic GANG_SEL_INDIVIDUAL  = 1'b0;
  localparam logic AUTO_STRAP_ENABLED   = 1'b0;
  localparam logic SERIAL_STRAP_SMBUS   = 1'b0;
  localparam logic POWER_STRAP_ENABLED  = 1'b0;
  // slave address bit position fed by the ganged strap
  localparam int   SLAVE_ADDR_BIT_POS   = 2;
  // downstream port number, counted from 1, losing charging downstream behaviour
  localparam int   CDP_BLOCKED_PORT     = 1;
  localparam int   NUM_PORTS            = 4;
  // synchroniser depth and final settle count; sampling follows four settle cycles after release
  localparam int   SYNC_DEPTH           = 3;
  localparam logic [1:0] SETTLE_CYCLES  = 2'h3;
  // reset values of latched straps (pin pull defaults)
  localparam logic GANG_RESET_VAL       = 1'b0;
  localparam logic AUTO_RESET_VAL       = 1'b1;
  localparam logic SERIAL_RESET_VAL     = 1'b1;
  localparam logic POWER_RESET_VAL      = 1'b1;

  // sampling phase, gray coded
  typedef enum logic [1:0] {
    SSSP_SETTLE = 2'b00,
    SSSP_SAMPLE = 2'b01,
    SSSP_RUN    = 2'b11
  } sssp_phase_t;
endpackage

// >>> verilog/sssp_strap_if.sv
// interface carrying synchronised pin levels between modules
`timescale 1ns/1ps
`default_nettype none
interface sssp_strap_if;
  logic gang_lvl;
  logic auto_lvl;
  logic serial_lvl;
  logic power_lvl;
  modport src (output gang_lvl, output auto_lvl,
               output serial_lvl, output power_lvl);
  modport dst (input gang_lvl, input auto_lvl,
               input serial_lvl, input power_lvl);
endinterface
`default_nettype wire

// >>> verilog/sssp_pin_sync.sv
// three flop synchronisers for the four strap pins
`timescale 1ns/1ps
`default_nettype none
module sssp_pin_sync (
  input  wire logic  clock_i,
  input  wire logic  reset_n_i,
  input  wire logic  gang_pin_i,
  input  wire logic  auto_pin_i,
  input  wire logic  serial_pin_i,
  input  wire logic  power_pin_i,
  sssp_strap_if.src  lvl
);
  import sssp_pkg::*;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] stable_q;

  // three stage chain, first stage read only by second
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else begin
      s1_q <= {power_pin_i, serial_pin_i, auto_pin_i, gang_pin_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stable_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          stable_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign lvl.gang_lvl   = stable_q[0];
  assign lvl.auto_lvl   = stable_q[1];
  assign lvl.serial_lvl = stable_q[2];
  assign lvl.power_lvl  = stable_q[3];
endmodule
`default_nettype wire

// >>> testbench/sssp_board_model.sv
// board strap resistors and status indicator loads on two pins
`timescale 1ns/1ps
`default_nettype none
module sssp_board_model (
  input  wire logic gang_strap_i,
  input  wire logic auto_strap_i,
  input  wire logic gang_o_i,
  input  wire logic gang_oe_i,
  input  wire logic auto_o_i,
  input  wire logic auto_oe_i,
  output var  logic gang_wire_o,
  output var  logic auto_wire_o
);
  // resistor sets the level whenever the device lets go of the pin
  // charging boards strap the ganged pin low (per-port power)
  assign gang_wire_o = gang_oe_i ? gang_o_i : gang_strap_i;
  assign auto_wire_o = auto_oe_i ? auto_o_i : auto_strap_i;
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for strap sampling and status pin reuse
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sssp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, gs = 1'b0, as = 1'b1, ss = 1'b1;
  logic ps = 1'b1, sen = 1'b0, hsc = 1'b0, hss = 1'b0, hubc = 1'b0;
  logic [NUM_PORTS-1:0] cen = '0, cdp;
  logic gw, aw, go, goe, ao, aoe, vld, gp, pse, smb, sa2, adis, act;
  int   fails = 0, cmp_count = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  sssp_board_model u_sssp_board_model (.gang_strap_i(gs), .auto_strap_i(as),
    .gang_o_i(go), .gang_oe_i(goe), .auto_o_i(ao), .auto_oe_i(aoe),
    .gang_wire_o(gw), .auto_wire_o(aw));
  sssp_strap_top u_sssp_strap_top (.clock_i(clk), .reset_n_i(rst_n),
    .gang_pin_i(gw), .gang_pin_o(go), .gang_pin_oe_o(goe),
    .charge_auto_strap_i(aw), .charge_auto_strap_o(ao),
    .charge_auto_strap_oe_o(aoe), .serial_mode_strap_i(ss),
    .power_switch_strap_i(ps), .status_pin_enable_i(sen),
    .hs_connected_i(hsc), .hs_suspended_i(hss), .hub_connected_i(hubc),
    .charge_port_en_i(cen), .straps_valid_o(vld), .ganged_power_o(gp),
    .power_switch_en_o(pse), .smbus_mode_o(smb),
    .slave_addr_bit_two_o(sa2), .auto_charge_disable_bit_o(adis),
    .auto_charge_active_o(act), .cdp_allowed_o(cdp));
  // compare, count, report
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("TB counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // reset with given straps, check reset then decoded values
  task automatic t_straps(input logic g, a, s, p, h, input logic [3:0] ce);
    @(posedge clk);
    rst_n <= 1'b0;
    {gs, as, ss, ps, hubc, cen, sen} <= {g, a, s, p, h, ce, 1'b0};
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({vld, gp, goe, aoe}, 4'h0);
    chk({adis, pse, smb, act}, 4'h8);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({vld, gp, pse}, {1'b1, g & ~p, ~p});
    chk({smb, sa2}, {~s, ~s & g});
    chk({adis, act}, {a, ~a & ~h});
    chk(cdp, ce & {4{h}} & {3'h7, a});
    chk({goe, aoe}, 2'h0);
    // flip every strap after sampling; latched values must hold
    @(posedge clk);
    {gs, as, ss, ps} <= {~g, ~a, ~s, ~p};
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk({gp, pse, smb, sa2}, {g & ~p, ~p, ~s, ~s & g});
    chk(adis, a);
    $display("TB test straps %b%b%b%b done", g, a, s, p);
  endtask
  // status drive on both pins and release when disabled
  task automatic t_status;
    @(posedge clk);
    {sen, hsc, hss} <= 3'b110;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({goe, gw, aoe, aw}, 4'hE);
    @(posedge clk);
    {hsc, hss} <= 2'b01;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({goe, gw, aoe, aw}, 4'hB);
    @(posedge clk);
    sen <= 1'b0;
    hsc <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({goe, aoe}, 2'h0);
    $display("TB test status done");
  endtask
  // watchdog
  initial begin
    #(100 * 4000);
    fails++;
    tally_and_finish();
  end
  initial begin
    t_straps(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
    t_straps(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF);
    t_straps(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0);
    t_straps(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'h5);
    t_status();
    tally_and_finish();
  end
endmodule
`default_nettype wire
